//--- spfc_top.sv
// Overview of operation
// - armed counter measures between gate transitions: any edge in buffered mode, active to inactive in single mode
// - count only selected source edge polarity
// - buffered mode: every gate edge saves count unless duplicate count prevention skips it
// - each buffered capture offered to dma engine
// - buffered mode counting starts at arm; first value partial
// - single semi-period equals single pulse-width
// - pulse mode emits pulse of n source periods
// - internal output routable to peer counter gate
// - async gate may shift count by one
// - single mode latches at inactive, then ignores
// - counter and save registers are 32 bits
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module spfc_top
    import spfc_pkg::*;
#(
    parameter int unsigned CNT_W = 32
)(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // register port
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wr_data,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [31:0]      o_rd_data,
    // measurement inputs
    input  wire logic             i_gate,
    input  wire logic             i_source,
    input  wire logic             i_peer_out,
    // internal output toward a peer counter
    output logic                  o_int_out,
    // dma request side
    output logic                  o_dma_req,
    output logic      [CNT_W-1:0] o_dma_data
);

    // ======================================================================
    // state
    // ======================================================================
    spfc_state_t            state_ff;
    spfc_state_t            nxt_state;
    logic [CTRL_W-1:0]      ctrl_ff;
    logic [CNT_W-1:0]       pulse_n_ff;
    logic [CNT_W-1:0]       count_ff;
    logic [CNT_W-1:0]       nxt_count;
    logic [CNT_W-1:0]       save_ff;
    logic                   dma_req_ff;
    logic                   int_out_ff;
    logic                   seen_src_ff;
    logic [31:0]            rd_data_ff;
    logic                   gate_m_ff;
    logic                   gate_s_ff;
    logic                   gate_d_ff;
    logic                   src_m_ff;
    logic                   src_s_ff;
    logic                   src_d_ff;

    // ======================================================================
    // decode
    // ======================================================================
    wire spfc_mode_t mode       = spfc_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
    wire             src_fall   = ctrl_ff[CTRL_SRC_FALL];
    wire             gate_low   = ctrl_ff[CTRL_GATE_LOW];
    wire             dcp_en     = ctrl_ff[CTRL_DCP];
    // peer output is on our clock already, so it skips the synchroniser
    wire             gate_now   = ctrl_ff[CTRL_GATE_PEER] ? i_peer_out : gate_s_ff;
    wire             gate_edge  = gate_now ^ gate_d_ff;
    wire             gate_act   = gate_now ^ gate_low;
    wire             gate_to_on = gate_edge & gate_act;
    wire             gate_to_off= gate_edge & ~gate_act;
    wire             src_act    = src_fall ? (src_d_ff & ~src_s_ff)
                                           : (src_s_ff & ~src_d_ff);
    wire             cmd_wr     = i_wr & (i_addr == REG_CMD);
    wire             arm        = cmd_wr & i_wr_data[CMD_ARM];
    wire             disarm     = cmd_wr & i_wr_data[CMD_DISARM];
    wire             in_count   = (state_ff == ST_COUNT);
    wire [CNT_W-1:0] cnt_inc    = count_ff + {{(CNT_W-1){1'b0}}, src_act};
    // duplicate count prevention: skip a gate edge with no source edge since
    wire             dcp_ok     = ~dcp_en | seen_src_ff | src_act;
    wire             buf_cap    = in_count & (mode == MODE_BUF_SEMI)
                                  & gate_edge & dcp_ok;
    wire             single_end = in_count & (mode == MODE_SINGLE) & gate_to_off;
    wire             pulse_end  = in_count & (mode == MODE_PULSE) & src_act
                                  & (cnt_inc >= pulse_n_ff);
    wire             arm_ok     = arm & (mode != MODE_RSVD);

    // ======================================================================
    // next state
    // ======================================================================
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE, ST_DONE:
            begin
                if (disarm)
                    nxt_state = ST_IDLE;
                else if (arm_ok)
                    nxt_state = (mode == MODE_BUF_SEMI) ? ST_COUNT : ST_WAIT;
            end
            ST_WAIT:
            begin
                // single mode armed mid-pulse waits for the next move into the active level; pulse mode waits for a source edge
                if (disarm)
                    nxt_state = ST_IDLE;
                else if ((mode == MODE_SINGLE) && gate_to_on)
                    nxt_state = ST_COUNT;
                else if ((mode == MODE_PULSE) && src_act)
                    nxt_state = ST_COUNT;
            end
            ST_COUNT:
            begin
                if (disarm)
                    nxt_state = ST_IDLE;
                else if (single_end || pulse_end)
                    nxt_state = ST_DONE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_comb
    begin
        nxt_count = count_ff;
        if (!in_count)
        begin
            if (state_ff != ST_DONE || arm_ok)
                nxt_count = '0;
        end
        else if (buf_cap)
            nxt_count = '0;
        else
            nxt_count = cnt_inc;
    end

    // ======================================================================
    // register port
    // ======================================================================
    wire [31:0] status_word = {29'h0, int_out_ff, (state_ff == ST_DONE),
                               (state_ff != ST_IDLE) && (state_ff != ST_DONE)};
    wire [31:0] rd_mux =
        (i_addr == REG_CTRL)    ? {{(32-CTRL_W){1'b0}}, ctrl_ff} :
        (i_addr == REG_STATUS)  ? status_word :
        (i_addr == REG_COUNT)   ? 32'(count_ff) :
        (i_addr == REG_SAVE)    ? 32'(save_ff) :
        (i_addr == REG_PULSE_N) ? 32'(pulse_n_ff) : 32'h0000_0000;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ctrl_ff    <= CTRL_RST;
            pulse_n_ff <= CNT_W'(PULSE_N_RST);
            rd_data_ff <= 32'h0000_0000;
        end
        else
        begin
            if (i_wr && (i_addr == REG_CTRL))
                ctrl_ff <= i_wr_data[CTRL_W-1:0];
            if (i_wr && (i_addr == REG_PULSE_N))
                pulse_n_ff <= i_wr_data[CNT_W-1:0];
            rd_data_ff <= i_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ======================================================================
    // synchronisers; a count may be off by one from sampling phase
    // ======================================================================
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            {gate_m_ff, gate_s_ff, gate_d_ff} <= 3'h0;
            {src_m_ff, src_s_ff, src_d_ff}    <= 3'h0;
        end
        else
        begin
            {gate_m_ff, gate_s_ff, gate_d_ff} <= {i_gate, gate_m_ff, gate_now};
            {src_m_ff, src_s_ff, src_d_ff}    <= {i_source, src_m_ff, src_s_ff};
        end
    end

    // ======================================================================
    // counter core
    // ======================================================================
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            state_ff    <= ST_IDLE;
            count_ff    <= '0;
            save_ff     <= '0;
            dma_req_ff  <= 1'b0;
            int_out_ff  <= 1'b0;
            seen_src_ff <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            count_ff    <= nxt_count;
            dma_req_ff  <= buf_cap;
            int_out_ff  <= (nxt_state == ST_COUNT) && (mode == MODE_PULSE);
            seen_src_ff <= in_count & ~buf_cap & (seen_src_ff | src_act);
            if (buf_cap || single_end)
                save_ff <= cnt_inc;
        end
    end

    assign o_rd_data  = rd_data_ff;
    assign o_int_out  = int_out_ff;
    assign o_dma_req  = dma_req_ff;
    assign o_dma_data = save_ff;

    // ======================================================================
    // checks
    // ======================================================================
    logic [CNT_W-1:0] pw_edges_ff;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b || !int_out_ff)
            pw_edges_ff <= '0;
        else if (src_act)
            pw_edges_ff <= pw_edges_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_dma_buf_only: assert property (o_dma_req |-> $past(mode) == MODE_BUF_SEMI)
        else $error("dma request outside buffered mode");
    a_capture_req: assert property (buf_cap |=> o_dma_req)
        else $error("gate edge did not raise dma request");
    a_capture_data: assert property (buf_cap |=> o_dma_data == $past(cnt_inc))
        else $error("dma data not the captured count");
    a_restart_zero: assert property (buf_cap && !disarm |=> count_ff == '0)
        else $error("count not restarted after capture");
    a_count_src_only: assert property (in_count && !src_act && !buf_cap && !disarm
                                       |=> $stable(count_ff))
        else $error("count moved without source edge");
    a_single_ignore: assert property (state_ff == ST_DONE && !arm ##1 state_ff == ST_DONE
                                      |-> $stable(save_ff) && $stable(count_ff))
        else $error("single mode result changed after latch");
    a_single_latch: assert property (single_end && !disarm
                                     |=> state_ff == ST_DONE && save_ff == $past(cnt_inc))
        else $error("single mode did not latch on inactive gate");
    a_buf_arm: assert property (state_ff == ST_IDLE && arm && !disarm
                                && mode == MODE_BUF_SEMI |=> in_count && count_ff == '0)
        else $error("buffered arm did not start counting");
    a_pulse_width: assert property ($fell(int_out_ff) && !$past(disarm) && pulse_n_ff != '0
                                    |-> pw_edges_ff == pulse_n_ff)
        else $error("output pulse not n source periods");

    c_buf_capture: cover property (buf_cap ##[1:200] buf_cap);
    c_single_done: cover property (single_end);
    c_pulse_done:  cover property (pulse_end);
    c_dcp_skip:    cover property (in_count && gate_edge && !dcp_ok);

endmodule // spfc_top

`default_nettype wire

//--- spfc_pkg.sv
// ==========================================================================
// shared constants for the semi-period / frequency counter
// ==========================================================================
package spfc_pkg;

    // ======================================================================
    // register map (byte addresses, one 32-bit word each)
    // ======================================================================
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_CMD     = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_COUNT   = 8'h0C;
    localparam logic [7:0] REG_SAVE    = 8'h10;
    localparam logic [7:0] REG_PULSE_N = 8'h14;

    // ======================================================================
    // field positions
    // ======================================================================
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_SRC_FALL  = 2;
    localparam int unsigned CTRL_GATE_LOW  = 3;
    localparam int unsigned CTRL_DCP       = 4;
    localparam int unsigned CTRL_GATE_PEER = 5;
    localparam int unsigned CTRL_W         = 6;
    localparam int unsigned CMD_ARM        = 0;
    localparam int unsigned CMD_DISARM     = 1;
    localparam int unsigned STAT_ARMED     = 0;
    localparam int unsigned STAT_DONE      = 1;
    localparam int unsigned STAT_OUT       = 2;

    // ======================================================================
    // reset values
    // ======================================================================
    localparam logic [5:0]  CTRL_RST    = 6'h00;
    localparam logic [31:0] PULSE_N_RST = 32'h0000_0001;

    // ======================================================================
    // types
    // ======================================================================
    typedef enum logic [1:0] {
        MODE_SINGLE   = 2'h0,
        MODE_BUF_SEMI = 2'h1,
        MODE_PULSE    = 2'h2,
        MODE_RSVD     = 2'h3
    } spfc_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_COUNT = 4'h4,
        ST_DONE  = 4'h8
    } spfc_state_t;

endpackage

//--- spfc_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// far side: free-running reference clock and gate generator
// ==========================================================================
module spfc_far_model (
    // clock and control
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic [7:0] i_semi,
    // measurement pins
    output logic            o_gate,
    output logic            o_source
);
    logic [2:0] ph_ff = 3'h0;
    logic [7:0] gcnt_ff = 8'h0;
    logic       on_ff = 1'b0;
    logic       gate_ff = 1'b0;

    // gate toggles on phases 2 and 6 only, never with a source edge
    always @(posedge i_clk)
    begin
        ph_ff   <= ph_ff + 3'h1;
        gcnt_ff <= gcnt_ff + 8'h1;
        if (i_run && !on_ff && ph_ff == 3'h1)
        begin
            on_ff   <= 1'b1;
            gcnt_ff <= 8'h1;
            gate_ff <= ~gate_ff;
        end
        else if (on_ff && gcnt_ff == i_semi)
        begin
            gcnt_ff <= 8'h1;
            gate_ff <= ~gate_ff;
        end
        if (!i_run)
            on_ff <= 1'b0;
    end

    // reference timebase, 8 clocks a period
    // slow reference so long gates still fit the count
    assign o_source = (ph_ff < 3'h4);
    assign o_gate   = gate_ff;

endmodule  // spfc_far_model

`default_nettype wire

//--- semi_period_freq_counter_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error %0t: got %0h exp %0h", $time, g, e); \
        end \
    end

module semi_period_freq_counter_tb
    import spfc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        gate;
    logic        src;
    logic        peer = 1'b0;
    logic        int_out;
    logic        dma_req;
    logic [31:0] dma_data;
    logic        run = 1'b0;
    logic [7:0]  semi = 8'h0C;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #2.5 clk = ~clk;

    spfc_top u_spfc_top (
        .i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wdata),
        .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_gate(gate),
        .i_source(src), .i_peer_out(peer), .o_int_out(int_out),
        .o_dma_req(dma_req), .o_dma_data(dma_data)
    );

    spfc_far_model u_spfc_far_model (
        .i_clk(clk), .i_run(run), .i_semi(semi), .o_gate(gate), .o_source(src)
    );

    // ======================================================================
    // bus tasks and expectations
    // ======================================================================
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // semi-period of 8k+4 clocks: windows alternate in edge content
    function automatic int exp_cnt(int k, int j, logic f);
        return f ? k + 1 - (j & 1) : k + (j & 1);
    endfunction

    task automatic get_cap(output logic [31:0] v);
        int t;
        t = 0;
        do
        begin
            @(posedge clk);
            #1 t++;
        end while (dma_req !== 1'b1 && t < 300);
        if (t >= 300)
        begin
            n_errors++;
            $display("Error %0t: no capture", $time);
            report_and_stop();
        end
        else
        begin
            v = dma_data;
            @(posedge clk);
            #1 `CHK(dma_req, 1'b0)
        end
    endtask

    task automatic run_buf(input logic f);
        logic [31:0] v;
        int k;
        k = $urandom_range(5, 1);
        run <= 1'b0;
        wr_reg(REG_CMD, 32'h2);
        wr_reg(REG_CTRL, {29'h0, f, 2'h1});
        semi <= 8'(k * 8 + 4);
        wr_reg(REG_CMD, 32'h1);
        run <= 1'b1;
        // first value is partial and dropped, five captures in all
        get_cap(v);
        for (int j = 0; j < 4; j++)
        begin
            get_cap(v);
            `CHK(v, 32'(exp_cnt(k, j, f)))
        end
        $display("buffered test done, falling=%0d", f);
    endtask

    // ======================================================================
    // main sequence
    // ======================================================================
    initial
    begin
        logic [31:0] d;
        int k;
        int w;
        int n;
        void'($urandom(32'hBAD8C9EB));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(REG_CTRL, d);
        `CHK(d, 32'h0)
        rd_reg(REG_PULSE_N, d);
        `CHK(d, PULSE_N_RST)
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_reg(8'h20, d);
        `CHK(d, 32'h0)
        wr_reg(REG_PULSE_N, 32'hFFFF_FFFF);
        rd_reg(REG_PULSE_N, d);
        `CHK(d, 32'hFFFF_FFFF)
        $display("register test done");

        for (int i = 0; i < 2; i++)
        begin
            n = i ? $urandom_range(4, 2) : 1;
            wr_reg(REG_CTRL, 32'h2);
            wr_reg(REG_PULSE_N, 32'(n));
            wr_reg(REG_CMD, 32'h1);
            w = 0;
            repeat (400)
            begin
                @(posedge clk);
                #1 w += (int_out === 1'b1);
            end
            `CHK(w, n * 8)
            rd_reg(REG_STATUS, d);
            `CHK(d[STAT_DONE], 1'b1)
        end
        $display("pulse test done");

        k = $urandom_range(4, 1);
        wr_reg(REG_CTRL, 32'h0);
        semi <= 8'(k * 8 + 4);
        wr_reg(REG_CMD, 32'h1);
        run <= 1'b1;
        w = 0;
        do
        begin
            rd_reg(REG_STATUS, d);
            w++;
        end while (d[STAT_DONE] !== 1'b1 && w < 100);
        `CHK(d[STAT_DONE], 1'b1)
        rd_reg(REG_SAVE, d);
        `CHK(d, 32'(k))
        semi <= 8'(k * 8 + 20);
        repeat (150)
        begin
            @(posedge clk);
            #1 `CHK(dma_req, 1'b0)
        end
        rd_reg(REG_SAVE, d);
        `CHK(d, 32'(k))
        $display("single test done");

        // known-width gate from the peer input, both active levels
        for (int p = 0; p < 2; p++)
        begin
            n = $urandom_range(6, 1);
            peer <= p[0];
            wr_reg(REG_CTRL, 32'h20 | 32'(p * 8));
            wr_reg(REG_CMD, 32'h1);
            peer <= ~p[0];
            repeat (8 * n) @(posedge clk);
            peer <= p[0];
            repeat (4) @(posedge clk);
            rd_reg(REG_SAVE, d);
            `CHK(d, 32'(n))
        end
        $display("peer gate test done");

        // gate toggling every cycle: only edges after a source edge capture
        wr_reg(REG_CTRL, 32'h31);
        wr_reg(REG_CMD, 32'h1);
        w = 0;
        for (int i = 0; i < 70; i++)
        begin
            @(posedge clk);
            if (i < 63)
                peer <= ~peer;
            #1 if (dma_req === 1'b1)
            begin
                w++;
                `CHK(dma_data, 32'h1)
            end
        end
        `CHK(w, 8)
        $display("duplicate count test done");

        run_buf(1'b0);
        run_buf(1'b1);
        report_and_stop();
    end

endmodule  // semi_period_freq_counter_tb

`default_nettype wire
